// *** hw/spis_pkg.sv ***
// Purpose: shared constants for the stack pointer and interrupt sequencer
// Assumes: APB register map, 32-bit data, one word per register
// Notes: printed offsets are register indices; byte address is four times index
package spis_pkg;
   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] SPIS_IDX_SP_LOW = 8'h3d;
   localparam logic [7:0] SPIS_IDX_SP_HIGH = 8'h3e;
   localparam logic [7:0] SPIS_IDX_STATUS = 8'h3f;
   localparam logic [7:0] SPIS_IDX_IRQ_EN = 8'h3b;
   localparam logic [7:0] SPIS_IDX_IRQ_FLAG = 8'h3a;
   localparam logic [7:0] SPIS_IDX_VECTOR = 8'h39;
   localparam logic [7:0] SPIS_IDX_SEQ = 8'h38;
   localparam logic [11:0] SPIS_ADDR_SP_LOW = {2'h0, SPIS_IDX_SP_LOW, 2'h0};
   localparam logic [11:0] SPIS_ADDR_SP_HIGH = {2'h0, SPIS_IDX_SP_HIGH, 2'h0};
   localparam logic [11:0] SPIS_ADDR_STATUS = {2'h0, SPIS_IDX_STATUS, 2'h0};
   localparam logic [11:0] SPIS_ADDR_IRQ_EN = {2'h0, SPIS_IDX_IRQ_EN, 2'h0};
   localparam logic [11:0] SPIS_ADDR_IRQ_FLAG = {2'h0, SPIS_IDX_IRQ_FLAG, 2'h0};
   localparam logic [11:0] SPIS_ADDR_VECTOR = {2'h0, SPIS_IDX_VECTOR, 2'h0};
   localparam logic [11:0] SPIS_ADDR_SEQ = {2'h0, SPIS_IDX_SEQ, 2'h0};
   // ****************************************************************
   // Field positions and timing
   // ****************************************************************
   localparam int SPIS_GIE_BIT = 7;
   localparam logic [3:0] SPIS_ENTRY_CYCLES = 4'h4;
   localparam logic [3:0] SPIS_RETURN_CYCLES = 4'h4;
   localparam logic [3:0] SPIS_WAKE_EXTRA = 4'h4;
   localparam logic [15:0] SPIS_STEP_ONE = 16'h0001;
   localparam logic [15:0] SPIS_STEP_TWO = 16'h0002;
   localparam logic [15:0] SPIS_RESET_VECTOR = 16'h0000;
   localparam logic [15:0] SPIS_TOP_OF_DATA_MEMORY = 16'h025f;
   // ****************************************************************
   // Core operations
   // ****************************************************************
   typedef enum logic [2:0] {
      SPIS_OP_NONE = 3'h0,
      SPIS_OP_STORE = 3'h1,
      SPIS_OP_LOAD = 3'h2,
      SPIS_OP_CALL = 3'h3,
      SPIS_OP_RET = 3'h4,
      SPIS_OP_HRET = 3'h5,
      SPIS_OP_GSET = 3'h6,
      SPIS_OP_GCLR = 3'h7
   } spis_op_t;
   typedef enum logic [1:0] {
      SPIS_ST_RUN = 2'b00,
      SPIS_ST_ENTRY = 2'b01,
      SPIS_ST_RETURN = 2'b11
   } spis_state_t;
endpackage : spis_pkg

// *** hw/spis_prio_enc.sv ***
// Purpose: fixed priority picker, lowest index wins
// Assumes: request bit 0 is the highest priority source
// Notes: purely combinational
`timescale 1ns/100ps
module spis_prio_enc #(
   parameter int N = 8
) (
   input wire logic [N-1:0] req,
   output logic any,
   output logic [$clog2(N)-1:0] idx
);
   // Scan from the top so the lowest index is left standing
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = i[$clog2(N)-1:0];
         end
      end
   end
endmodule : spis_prio_enc

// *** hw/spis_sequencer.sv ***
// Purpose: stack pointer and reset/interrupt sequencing of a small core
// Assumes: core issues one op per cycle on op_valid; pclk is the core clock
// Notes: sources are synchronised here; stack bytes go to sram ports
`timescale 1ns/100ps
module spis_sequencer
   import spis_pkg::*;
#(
   parameter int N_SRC = 8,
   parameter int SP_BITS = 10,
   parameter logic [N_SRC-1:0] LEVEL_MASK = 8'h00
) (
   input wire logic pclk, // used directly, no divider
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   input wire logic [2:0] op_code,
   input wire logic [7:0] op_wdata,
   input wire logic [15:0] op_ret_addr,
   input wire logic instr_done,
   input wire logic sleeping,
   input wire logic [N_SRC-1:0] src_in,
   output logic sram_we,
   output logic sram_re,
   output logic [15:0] sram_addr,
   output logic [7:0] sram_wdata,
   input wire logic [7:0] sram_rdata,
   output logic [7:0] op_rdata,
   output logic irq_taken,
   output logic [15:0] vector_addr,
   output logic core_stall,
   output logic gie
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam logic [SP_BITS-1:0] SP_RST = SPIS_TOP_OF_DATA_MEMORY[SP_BITS-1:0];
   localparam logic [15:0] SP_KEEP = 16'hffff >> (16 - SP_BITS);
   logic [15:0] sp_reg, sp_next;
   logic gie_reg, gie_next;
   logic [N_SRC-1:0] en_reg;
   logic [N_SRC-1:0] flag_reg;
   logic [N_SRC-1:0] src_s1, src_s2, src_s3;
   logic [N_SRC-1:0] edge_ev, cond, req;
   logic hold_reg;
   logic [3:0] cnt_reg;
   spis_state_t state_reg;
   logic [15:0] vec_reg;
   logic pick_any;
   logic [$clog2(N_SRC)-1:0] pick_idx;
   logic take;
   logic [7:0] ret_hi_reg;
   logic wr_acc, rd_acc;
   logic [7:0] wbyte;
   logic op_is_gset, op_is_gclr;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
   assign op_is_gset = op_valid && (op_code == SPIS_OP_GSET);
   assign op_is_gclr = op_valid && (op_code == SPIS_OP_GCLR);
   // ****************************************************************
   // Source synchronisers and edge capture
   // ****************************************************************
   // Pins are asynchronous; first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_s1 <= '0;
         src_s2 <= '0;
         src_s3 <= '0;
      end else begin
         src_s1 <= src_in;
         src_s2 <= src_s1;
         src_s3 <= src_s2;
      end
   end
   assign edge_ev = src_s2 & ~src_s3 & ~LEVEL_MASK;
   assign cond = src_s2 & LEVEL_MASK; // live level, no latch
   // ****************************************************************
   // Interrupt flags
   // ****************************************************************
   // Event set wins over a software or vectoring clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= (flag_reg
            & ~((wr_acc && paddr == SPIS_ADDR_IRQ_FLAG && pstrb[0]) ? pwdata[N_SRC-1:0] : '0)
            & ~((take && !LEVEL_MASK[pick_idx]) ? (N_SRC'(1) << pick_idx) : '0))
            | edge_ev; // kept until served or cleared
      end
   end
   // Individual enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= '0;
      end else if (wr_acc && paddr == SPIS_ADDR_IRQ_EN && pstrb[0]) begin
         en_reg <= pwdata[N_SRC-1:0];
      end
   end
   // ****************************************************************
   // Arbitration
   // ****************************************************************
   assign req = (flag_reg | cond) & en_reg;
   spis_prio_enc #(.N(N_SRC)) u_prio (
      .req(req),
      .any(pick_any),
      .idx(pick_idx)
   );
   // same-cycle global clear vetoes; hold one instruction
   assign take = (state_reg == SPIS_ST_RUN) && pick_any && gie_reg && !op_is_gclr
      && !hold_reg && instr_done;
   // Hold-off after handler return or a global set while disabled, cleared by next instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 1'b0;
      end else if (state_reg == SPIS_ST_RETURN && cnt_reg == 4'h1) begin
         hold_reg <= 1'b1;
      end else if (op_is_gset && !gie_reg) begin
         hold_reg <= 1'b1;
      end else if (instr_done && state_reg == SPIS_ST_RUN) begin
         hold_reg <= 1'b0;
      end
   end
   // ****************************************************************
   // Entry and return sequencer
   // ****************************************************************
   // Entry pushes the low byte at acceptance and the high byte when the count equals SPIS_ENTRY_CYCLES
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SPIS_ST_RUN;
         cnt_reg <= 4'h0;
         vec_reg <= SPIS_RESET_VECTOR; // reset vector first
      end else begin
         case (state_reg)
            SPIS_ST_RUN: begin
               if (take) begin
                  state_reg <= SPIS_ST_ENTRY;
                  cnt_reg <= sleeping ? SPIS_ENTRY_CYCLES + SPIS_WAKE_EXTRA : SPIS_ENTRY_CYCLES;
                  vec_reg <= 16'(pick_idx) + SPIS_STEP_ONE; // index+1, reset at zero
               end else if (op_valid && op_code == SPIS_OP_HRET) begin
                  state_reg <= SPIS_ST_RETURN;
                  cnt_reg <= SPIS_RETURN_CYCLES;
               end
            end
            SPIS_ST_ENTRY, SPIS_ST_RETURN: begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h1) begin
                  state_reg <= SPIS_ST_RUN;
               end
            end
            default: begin
               state_reg <= SPIS_ST_RUN;
               cnt_reg <= 4'h0;
            end
         endcase
      end
   end
   assign core_stall = (state_reg != SPIS_ST_RUN);
   assign irq_taken = (state_reg == SPIS_ST_ENTRY) && (cnt_reg == 4'h1);
   assign vector_addr = vec_reg;
   // ****************************************************************
   // Global enable
   // ****************************************************************
   // Status register holds only this bit here; other flags live in the ALU
   always_comb begin
      gie_next = gie_reg;
      if (op_is_gset) gie_next = 1'b1;
      if (op_is_gclr) gie_next = 1'b0;
      if (wr_acc && paddr == SPIS_ADDR_STATUS && pstrb[0]) gie_next = pwdata[SPIS_GIE_BIT];
      if (state_reg == SPIS_ST_RETURN && cnt_reg == 4'h1) gie_next = 1'b1;
      if (take) gie_next = 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gie_reg <= 1'b0;
      else gie_reg <= gie_next;
   end
   assign gie = gie_reg;
   // ****************************************************************
   // Stack pointer
   // ****************************************************************
   // Downward growth: stores decrement, loads increment
   // Each stack op settles within its one clock, matching the single-cycle ALU path
   always_comb begin
      sp_next = sp_reg;
      if (take) begin
         sp_next = sp_reg - SPIS_STEP_TWO;
      end else if (state_reg == SPIS_ST_RUN && op_valid) begin
         case (op_code)
            SPIS_OP_STORE: sp_next = sp_reg - SPIS_STEP_ONE;
            SPIS_OP_LOAD: sp_next = sp_reg + SPIS_STEP_ONE;
            SPIS_OP_CALL: sp_next = sp_reg - SPIS_STEP_TWO;
            SPIS_OP_RET, SPIS_OP_HRET: sp_next = sp_reg + SPIS_STEP_TWO;
            default: sp_next = sp_reg;
         endcase
      end else if (wr_acc && paddr == SPIS_ADDR_SP_LOW && pstrb[0]) begin
         sp_next = {sp_reg[15:8], wbyte};
      end else if (wr_acc && paddr == SPIS_ADDR_SP_HIGH && pstrb[0]) begin
         sp_next = {wbyte, sp_reg[7:0]};
      end
      sp_next = sp_next & SP_KEEP;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sp_reg <= {{(16 - SP_BITS){1'b0}}, SP_RST};
      else sp_reg <= sp_next;
   end
   // ****************************************************************
   // Stack memory port
   // ****************************************************************
   // Byte pushes write at pointer then move; pops move then read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sram_we <= 1'b0;
         sram_re <= 1'b0;
         sram_addr <= 16'h0000;
         sram_wdata <= 8'h00;
         ret_hi_reg <= 8'h00;
      end else begin
         sram_we <= 1'b0;
         sram_re <= 1'b0;
         if (take) begin
            sram_we <= 1'b1;
            sram_addr <= sp_reg; // low byte first
            sram_wdata <= op_ret_addr[7:0];
            ret_hi_reg <= op_ret_addr[15:8];
         end else if (state_reg == SPIS_ST_ENTRY && cnt_reg == SPIS_ENTRY_CYCLES) begin
            sram_we <= 1'b1;
            sram_addr <= (sp_reg + SPIS_STEP_ONE) & SP_KEEP;
            sram_wdata <= ret_hi_reg;
         end else if (state_reg == SPIS_ST_RUN && op_valid && op_code == SPIS_OP_STORE) begin
            sram_we <= 1'b1;
            sram_addr <= sp_reg;
            sram_wdata <= op_wdata;
         end else if (state_reg == SPIS_ST_RUN && op_valid && op_code == SPIS_OP_LOAD) begin
            sram_re <= 1'b1;
            sram_addr <= sp_next;
         end
      end
   end
   assign op_rdata = sram_rdata; // byte from the stack
   // ****************************************************************
   // APB read side
   // ****************************************************************
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SPIS_ADDR_SP_LOW: prdata <= {24'h000000, sp_reg[7:0]};
            SPIS_ADDR_SP_HIGH: prdata <= {24'h000000, sp_reg[15:8]};
            SPIS_ADDR_STATUS: prdata <= {24'h000000, gie_reg, 7'h00};
            SPIS_ADDR_IRQ_EN: prdata <= 32'(en_reg);
            SPIS_ADDR_IRQ_FLAG: prdata <= 32'(flag_reg);
            SPIS_ADDR_VECTOR: prdata <= {16'h0000, vec_reg};
            SPIS_ADDR_SEQ: prdata <= {28'h0000000, hold_reg, core_stall, state_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
   // ****************************************************************
   // Checks
   // ****************************************************************
   // Multi-step entry and return are written as named sequences
   sequence entry_s;
      take ##1 core_stall [*4];
   endsequence
   sequence ret_s;
      core_stall [*4] ##1 gie_reg;
   endsequence
   entry_len_a: assert property (@(posedge pclk) disable iff (!presetn) take |-> entry_s)
      else $error("entry shorter than four cycles");
   entry_gie_a: assert property (@(posedge pclk) disable iff (!presetn) take |=> !gie_reg)
      else $error("global enable kept after accept");
   entry_sp_a: assert property (@(posedge pclk) disable iff (!presetn)
      take |=> sp_reg == (($past(sp_reg) - SPIS_STEP_TWO) & SP_KEEP))
      else $error("entry pointer not minus two");
   gclr_block_a: assert property (@(posedge pclk) disable iff (!presetn) op_is_gclr |-> !take)
      else $error("interrupt taken with global clear");
   ret_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == SPIS_ST_RUN && op_valid && op_code == SPIS_OP_HRET && !take) |-> ##1 ret_s)
      else $error("global enable not set on return");
   store_sp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == SPIS_ST_RUN && !take && op_valid && op_code == SPIS_OP_STORE)
      |=> sram_we && sram_addr == $past(sp_reg) && sp_reg == (($past(sp_reg) - SPIS_STEP_ONE) & SP_KEEP))
      else $error("byte store wrong");
   take_en_a: assert property (@(posedge pclk) disable iff (!presetn) take |-> gie_reg && req[pick_idx])
      else $error("taken while disabled");
   hold_ret_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == SPIS_ST_RETURN && cnt_reg == 4'h1) |=> !take)
      else $error("no main instruction after return");
   sp_high_a: assert property (@(posedge pclk) disable iff (!presetn) (sp_reg & ~SP_KEEP) == 16'h0000)
      else $error("unused pointer bits set");
   load_sp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == SPIS_ST_RUN && !take && op_valid && op_code == SPIS_OP_LOAD)
      |=> sram_re && sram_addr == sp_reg && sp_reg == (($past(sp_reg) + SPIS_STEP_ONE) & SP_KEEP))
      else $error("byte load wrong");
   flag_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !LEVEL_MASK[pick_idx] && !edge_ev[pick_idx]) |=> !flag_reg[$past(pick_idx)])
      else $error("flag kept after vectoring");
   gclr_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
      (op_is_gclr && state_reg == SPIS_ST_RUN && !(wr_acc && paddr == SPIS_ADDR_STATUS && pstrb[0]))
      |=> !gie_reg)
      else $error("global enable kept after clear");
   gset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (op_is_gset && !gie_reg) |=> !take)
      else $error("interrupt before instruction after set");
endmodule : spis_sequencer

// *** bench/spis_stack_mem.sv ***
// Purpose: data memory model that holds the stack bytes
// Assumes: write and read strobes are one-cycle pulses from the sequencer
// Notes: read data is combinational, like a fast on-chip memory
`timescale 1ns/100ps
module spis_stack_mem (
   input wire logic pclk,
   input wire logic sram_we,
   input wire logic sram_re,
   input wire logic [15:0] sram_addr,
   input wire logic [7:0] sram_wdata,
   output logic [7:0] sram_rdata
);
   logic [7:0] mem [0:1023];
   logic [7:0] last_reg;
   // ****************************************************************
   // Storage
   // ****************************************************************
   // Only the low ten address bits exist, as in the sequencer
   always_ff @(posedge pclk) begin
      if (sram_we) begin
         mem[sram_addr[9:0]] <= sram_wdata;
      end
      if (sram_re) begin
         last_reg <= mem[sram_addr[9:0]];
      end
   end
   // Released bus shows the inverse of the last byte, so a late sample fails
   assign sram_rdata = sram_re ? mem[sram_addr[9:0]] : ~last_reg;
endmodule : spis_stack_mem

// *** bench/tb.sv ***
// Purpose: self-checking bench for the stack pointer and interrupt sequencer
// Assumes: sources are synchronised inside the design
// Notes: instr_done held high, so every cycle is an instruction boundary
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module tb;
   import spis_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, op_valid, instr_done, sleeping;
   logic pready, pslverr, sram_we, sram_re, irq_taken, core_stall, gie;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [2:0] op_code;
   logic [7:0] op_wdata, sram_wdata, sram_rdata, op_rdata, src_in;
   logic [15:0] op_ret_addr, sram_addr, vector_addr, sp;
   logic seen;
   int errors, checks, cycles, stl;
   spis_sequencer #(.N_SRC(8), .SP_BITS(10), .LEVEL_MASK(8'h80)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
      .op_wdata(op_wdata), .op_ret_addr(op_ret_addr), .instr_done(instr_done), .sleeping(sleeping),
      .src_in(src_in), .sram_we(sram_we), .sram_re(sram_re), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
      .sram_rdata(sram_rdata), .op_rdata(op_rdata), .irq_taken(irq_taken), .vector_addr(vector_addr),
      .core_stall(core_stall), .gie(gie));
   spis_stack_mem u_mem (.pclk(pclk), .sram_we(sram_we), .sram_re(sram_re), .sram_addr(sram_addr),
      .sram_wdata(sram_wdata), .sram_rdata(sram_rdata));
   // ****************************************************************
   // Bus and core helpers
   // ****************************************************************
   // APB cycle; waits on pready with no assumed latency
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task get_sp();
      apb(1'b0, SPIS_ADDR_SP_HIGH, 8'h00);
      sp[15:8] = rd[7:0];
      apb(1'b0, SPIS_ADDR_SP_LOW, 8'h00);
      sp[7:0] = rd[7:0];
   endtask : get_sp
   // One op, held for exactly one edge
   task op(input spis_op_t c);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= c;
      @(posedge pclk);
      op_valid <= 1'b0;
      op_code <= SPIS_OP_NONE;
   endtask : op
   // Sampled on the falling edge, clear of the design's own updates
   task wait_irq();
      seen = 1'b0;
      stl = 0;
      for (int n = 0; n < 40 && !seen; n++) begin
         @(negedge pclk);
         if (core_stall === 1'b1) stl++;
         if (irq_taken === 1'b1) seen = 1'b1;
      end
   endtask : wait_irq
   task wait_idle();
      for (int n = 0; n < 40; n++) begin
         @(negedge pclk);
         if (core_stall === 1'b0) break;
      end
   endtask : wait_idle
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_regs();
      get_sp();
      `CHK(sp, SPIS_TOP_OF_DATA_MEMORY)
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rd, 32'h00000000)
      `CHK(pslverr, 1'b0)
      apb(1'b1, SPIS_ADDR_SP_HIGH, 8'hff);
      apb(1'b1, SPIS_ADDR_SP_LOW, 8'h80);
      get_sp();
      `CHK(sp, 16'h0380)
      // Stack placed above the register and I/O area before any call
      apb(1'b1, SPIS_ADDR_SP_HIGH, 8'h01);
      get_sp();
      `CHK(sp, 16'h0180)
   endtask : t_regs
   task t_stack();
      op(SPIS_OP_STORE);
      #1;
      `CHK({sram_we, sram_addr, sram_wdata}, {1'b1, 16'h0180, 8'ha5})
      get_sp();
      `CHK(sp, 16'h017f)
      op(SPIS_OP_LOAD);
      #1;
      `CHK({sram_re, sram_addr, op_rdata}, {1'b1, 16'h0180, 8'ha5})
      op(SPIS_OP_CALL);
      get_sp();
      `CHK(sp, 16'h017e)
      op(SPIS_OP_RET);
      get_sp();
      `CHK(sp, 16'h0180)
   endtask : t_stack
   // Two sources pend while global enable is off, then served by priority
   task t_irq();
      apb(1'b1, SPIS_ADDR_IRQ_EN, 8'h05);
      src_in <= 8'h05;
      repeat (6) @(posedge pclk);
      apb(1'b0, SPIS_ADDR_IRQ_FLAG, 8'h00);
      `CHK(rd[7:0], 8'h05)
      op(SPIS_OP_GSET);
      wait_irq();
      `CHK(seen, 1'b1)
      `CHK(stl >= 4, 1'b1)
      `CHK({vector_addr, gie}, {16'h0001, 1'b0})
      apb(1'b0, SPIS_ADDR_IRQ_FLAG, 8'h00);
      `CHK(rd[7:0], 8'h04)
      get_sp();
      `CHK(sp, 16'h017e)
      // High byte of the pushed return address sits just below the low byte
      op(SPIS_OP_LOAD);
      #1;
      `CHK(op_rdata, 8'h12)
      op(SPIS_OP_STORE);
      op(SPIS_OP_HRET);
      wait_idle();
      `CHK(gie, 1'b1)
      wait_irq();
      `CHK(vector_addr, 16'h0003)
      op(SPIS_OP_HRET);
      wait_idle();
      get_sp();
      `CHK(sp, 16'h0180)
   endtask : t_irq
   // Global clear in the very cycle a new request first reaches arbitration
   task t_gclr();
      src_in <= 8'h00;
      repeat (4) @(posedge pclk);
      src_in <= 8'h01;
      repeat (3) @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= SPIS_OP_GCLR;
      @(posedge pclk);
      op_valid <= 1'b0;
      op_code <= SPIS_OP_NONE;
      wait_irq();
      `CHK({seen, gie}, 2'b00)
      apb(1'b1, SPIS_ADDR_IRQ_FLAG, 8'h00);
      apb(1'b0, SPIS_ADDR_IRQ_FLAG, 8'h00);
      `CHK(rd[7:0], 8'h01)
      apb(1'b1, SPIS_ADDR_IRQ_FLAG, 8'h01);
      apb(1'b0, SPIS_ADDR_IRQ_FLAG, 8'h00);
      `CHK(rd[7:0], 8'h00)
   endtask : t_gclr
   // Level source: a condition gone before enabling is lost; a live one is served
   task t_level();
      src_in <= 8'h80;
      repeat (4) @(posedge pclk);
      src_in <= 8'h00;
      repeat (4) @(posedge pclk);
      apb(1'b1, SPIS_ADDR_IRQ_EN, 8'h85);
      apb(1'b0, SPIS_ADDR_IRQ_FLAG, 8'h00);
      `CHK(rd[7:0], 8'h00)
      op(SPIS_OP_GSET);
      wait_irq();
      `CHK(seen, 1'b0)
      // Asleep at acceptance: entry stretches by the wake-up cycles
      @(posedge pclk);
      src_in <= 8'h80;
      sleeping <= 1'b1;
      wait_irq();
      `CHK(seen, 1'b1)
      `CHK(stl >= 8, 1'b1)
      `CHK({vector_addr, gie}, {16'h0008, 1'b0})
      @(posedge pclk);
      src_in <= 8'h00;
      sleeping <= 1'b0;
      op(SPIS_OP_HRET);
      wait_idle();
      `CHK(gie, 1'b1)
      wait_irq();
      `CHK(seen, 1'b0)
      get_sp();
      `CHK(sp, 16'h0180)
   endtask : t_level
   // ****************************************************************
   // Clock, watchdog, sequence
   // ****************************************************************
   task report_and_stop();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Run needs a few hundred cycles; the ceiling leaves wide margin
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         $display("Error at %0t: timeout", $time);
         report_and_stop();
      end
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, op_valid, sleeping, paddr, pwdata, op_code} = '0;
      pstrb = 4'h1;
      op_wdata = 8'ha5;
      op_ret_addr = 16'h1234;
      instr_done = 1'b1;
      src_in = 8'h00;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_stack();
      t_irq();
      t_gclr();
      t_level();
      report_and_stop();
   end
endmodule : tb
